// *** shared/vok_defs.svh ***
// Register indices, field positions, reset values and mode codes of the
// overlay key and capture window block. Assumes inclusion by bare name.
`ifndef VOK_DEFS_SVH
`define VOK_DEFS_SVH

// Indices of the data port
`define VOK_IDX_VKEY_BY_LOW 8'h9A
`define VOK_IDX_VKEY_GU_LOW 8'h9B
`define VOK_IDX_VKEY_RV_LOW 8'h9C
`define VOK_IDX_VIDEO_MISC3 8'h9D
`define VOK_IDX_GKEY_B_HIGH 8'hA1
`define VOK_IDX_GKEY_G_HIGH 8'hA2
`define VOK_IDX_GKEY_R_HIGH 8'hA3
`define VOK_IDX_VKEY_BY_HIGH 8'hA4
`define VOK_IDX_VKEY_GU_HIGH 8'hA5
`define VOK_IDX_VKEY_RV_HIGH 8'hA6
`define VOK_IDX_GFX_WEIGHT 8'hA7
`define VOK_IDX_VID_WEIGHT 8'hA8
`define VOK_IDX_MODE 8'hA9
`define VOK_IDX_LEFT_LOW 8'hAA
`define VOK_IDX_RIGHT_LOW 8'hAB
`define VOK_IDX_TOP_LOW 8'hAC
`define VOK_IDX_BOTTOM_LOW 8'hAD
`define VOK_IDX_H_OVERFLOW 8'hAE
`define VOK_IDX_V_OVERFLOW 8'hAF

// Reset value of every register
`define VOK_REG_RESET 8'h00

// Field positions
`define VOK_KEY_FMT_BIT 2
`define VOK_MODE_MSB 3
`define VOK_WEIGHT_MSB 7
`define VOK_WEIGHT_LSB 5
`define VOK_HOVF_END_MSB 6
`define VOK_HOVF_END_LSB 4
`define VOK_HOVF_START_MSB 2
`define VOK_VOVF_END_MSB 3
`define VOK_VOVF_END_LSB 2
`define VOK_VOVF_START_MSB 1
`define VOK_HOVF_MASK 8'h77
`define VOK_MODE_MASK 8'h0F

// Blend scale shift for 3-bit weights
`define VOK_BLEND_SHIFT 3

// Overlay mode codes
`define VOK_MODE_GFX 4'h0
`define VOK_MODE_AND 4'h1
`define VOK_MODE_C_NCH 4'h2
`define VOK_MODE_C 4'h3
`define VOK_MODE_NC_CH 4'h4
`define VOK_MODE_CH 4'h5
`define VOK_MODE_XOR 4'h6
`define VOK_MODE_OR 4'h7
`define VOK_MODE_NOR 4'h8
`define VOK_MODE_XNOR 4'h9
`define VOK_MODE_NCH_A 4'hA
`define VOK_MODE_C_OR_NCH 4'hB
`define VOK_MODE_NCH_B 4'hC
`define VOK_MODE_NC_OR_CH 4'hD
`define VOK_MODE_NAND 4'hE
`define VOK_MODE_BLEND 4'hF

// Graphics colour depth codes
`define VOK_DEPTH_8 2'h0
`define VOK_DEPTH_16 2'h1
`define VOK_DEPTH_24 2'h2

`endif

// *** shared/vok_pkg.sv ***
// Types of the overlay key and capture window block.
// Assumes vok_defs.svh for numeric constants other than the capture state codes.
package vok_pkg;

  typedef struct packed {
    logic [7:0] r;
    logic [7:0] g;
    logic [7:0] b;
  } vok_rgb_t;

  typedef struct packed {
    logic sel_data;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } vok_io_req_t;

  typedef enum logic [1:0] {
    VOK_CAP_WAIT_FRAME = 2'h0,
    VOK_CAP_IN_FRAME = 2'h1
  } vok_cap_state_t;

  typedef struct packed {
    logic [7:0] vkey_by_low;
    logic [7:0] vkey_gu_low;
    logic [7:0] vkey_rv_low;
    logic [7:0] video_misc3;
    logic [7:0] graphics_key_blue_high;
    logic [7:0] graphics_key_green_high;
    logic [7:0] graphics_key_red_high;
    logic [7:0] video_key_blue_luma_high;
    logic [7:0] video_key_green_u_high;
    logic [7:0] video_key_red_v_high;
    logic [7:0] graphics_blend_weight;
    logic [7:0] video_blend_weight;
    logic [7:0] overlay_select_mode;
    logic [7:0] capture_left_bound_low;
    logic [7:0] capture_right_bound_low;
    logic [7:0] capture_top_bound_low;
    logic [7:0] capture_bottom_bound_low;
    logic [7:0] capture_h_overflow;
    logic [7:0] capture_v_overflow;
  } vok_regs_t;

  typedef struct packed {
    vok_regs_t regs;
    logic [7:0] io_index;
    logic [7:0] io_rdata;
    logic [2:0] pin_s1;
    logic [2:0] pin_s2;
    logic [15:0] data_s1;
    logic [15:0] data_s2;
    logic vclk_d;
    logic vsync_d;
    logic blank_n_d;
    logic [10:0] hcnt;
    logic [9:0] vcnt;
    vok_cap_state_t cap_state;
    logic cap_valid;
    logic [15:0] cap_data;
    logic cap_window;
    vok_rgb_t mix_pix;
  } vok_state_t;

endpackage : vok_pkg

// *** logic/vok_overlay_capture.sv ***
// Overlay key mixer and capture window of the video unit.
// Assumes host I/O requests and pixel streams are synchronous to mclk_i;
// the video decoder pins come from their own clock and are synchronised.
`timescale 1ns/1ps

`include "vok_defs.svh"

module vok_overlay_capture
  import vok_pkg::*;
#(
  parameter int HCNT_W = 11,
  parameter int VCNT_W = 10,
  parameter int DATA_W = 16
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic reset_n_i,
  // Host indexed I/O port
  input wire vok_io_req_t io_req_i,
  output logic [7:0] io_rdata_o,
  // Graphics colour depth and colour key low value
  input wire logic [1:0] color_depth_i,
  input wire logic [23:0] graphics_key_low_i,
  // Pixel streams to and from the mixer
  input wire vok_rgb_t gfx_pix_i,
  input wire vok_rgb_t video_pix_i,
  output vok_rgb_t mix_pix_o,
  // Video decoder pins
  input wire logic vid_clk_i,
  input wire logic vid_blank_n_i,
  input wire logic video_in_vertical_sync_i,
  input wire logic [DATA_W-1:0] vid_data_i,
  // Captured stream
  output logic capture_valid_o,
  output logic [DATA_W-1:0] capture_data_o,
  output logic capture_window_o
);

  localparam int PIN_VCLK = 0;
  localparam int PIN_BLANK = 1;
  localparam int PIN_VSYNC = 2;

  vok_state_t st_reg;
  vok_state_t st_next;

  // Graphics value against colour key, width set by depth
  function automatic logic color_key_hit(
    input logic [23:0] pix,
    input logic [23:0] low,
    input logic [23:0] high,
    input logic [1:0] depth
  );
    logic [23:0] mask;
    logic [23:0] p;
    logic [23:0] l;
    logic [23:0] h;
    case (depth)
      `VOK_DEPTH_8: mask = 24'h0000FF;
      `VOK_DEPTH_16: mask = 24'h00FFFF;
      default: mask = 24'hFFFFFF;
    endcase
    // Masked bytes never reach the compare
    p = pix & mask;
    l = low & mask;
    h = high & mask;
    color_key_hit = (p >= l) && (p <= h);
  endfunction : color_key_hit

  // One component within an inclusive range
  function automatic logic in_range8(
    input logic [7:0] v,
    input logic [7:0] low,
    input logic [7:0] high
  );
    in_range8 = (v >= low) && (v <= high);
  endfunction : in_range8

  // Weighted sum of one component, saturated to a byte
  function automatic logic [7:0] blend8(
    input logic [7:0] g,
    input logic [7:0] v,
    input logic [2:0] gw,
    input logic [2:0] vw
  );
    logic [11:0] sum;
    logic [11:0] scaled;
    // Worst case 2 * 255 * 7 still fits twelve bits
    sum = 12'(g) * 12'(gw)
        + 12'(v) * 12'(vw);
    scaled = sum >> `VOK_BLEND_SHIFT;
    blend8 = (scaled > 12'h0FF) ? 8'hFF : scaled[7:0];
  endfunction : blend8

  // Blend select for each overlay mode
  function automatic logic mode_pick(
    input logic [3:0] mode,
    input logic ck,
    input logic ch
  );
    case (mode)
      `VOK_MODE_GFX: mode_pick = 1'b0;
      `VOK_MODE_AND: mode_pick = ck & ch;
      `VOK_MODE_C_NCH: mode_pick = ck & ~ch;
      `VOK_MODE_C: mode_pick = ck;
      `VOK_MODE_NC_CH: mode_pick = ~ck & ch;
      `VOK_MODE_CH: mode_pick = ch;
      `VOK_MODE_XOR: mode_pick = ck ^ ch;
      `VOK_MODE_OR: mode_pick = ck | ch;
      `VOK_MODE_NOR: mode_pick = ~ck & ~ch;
      `VOK_MODE_XNOR: mode_pick = ~(ck ^ ch);
      `VOK_MODE_NCH_A: mode_pick = ~ch;
      `VOK_MODE_C_OR_NCH: mode_pick = ck | ~ch;
      `VOK_MODE_NCH_B: mode_pick = ~ch;
      `VOK_MODE_NC_OR_CH: mode_pick = ~ck | ch;
      `VOK_MODE_NAND: mode_pick = ~ck | ~ch;
      `VOK_MODE_BLEND: mode_pick = 1'b1;
      default: mode_pick = 1'b0;
    endcase
  endfunction : mode_pick

  // Key flags, blend and window bounds
  logic color_key;
  logic chroma_key;
  logic [2:0] gfx_w;
  logic [2:0] vid_w;
  logic [3:0] mode;
  logic [23:0] gkey_high;
  vok_rgb_t blended;
  logic [HCNT_W-1:0] h_start;
  logic [HCNT_W-1:0] h_end;
  logic [VCNT_W-1:0] v_start;
  logic [VCNT_W-1:0] v_end;

  always_comb begin
    gkey_high = {st_reg.regs.graphics_key_red_high,
                 st_reg.regs.graphics_key_green_high,
                 st_reg.regs.graphics_key_blue_high};
    color_key = color_key_hit(gfx_pix_i, graphics_key_low_i, gkey_high,
                              color_depth_i);
    // Same byte lanes serve RGB and YUV; only their meaning changes
    chroma_key = in_range8(video_pix_i.b, st_reg.regs.vkey_by_low,
                           st_reg.regs.video_key_blue_luma_high)
               & in_range8(video_pix_i.g, st_reg.regs.vkey_gu_low,
                           st_reg.regs.video_key_green_u_high)
               & in_range8(video_pix_i.r, st_reg.regs.vkey_rv_low,
                           st_reg.regs.video_key_red_v_high);
    gfx_w = st_reg.regs.graphics_blend_weight[`VOK_WEIGHT_MSB:`VOK_WEIGHT_LSB];
    vid_w = st_reg.regs.video_blend_weight[`VOK_WEIGHT_MSB:`VOK_WEIGHT_LSB];
    mode = st_reg.regs.overlay_select_mode[`VOK_MODE_MSB:0];
    blended.r = blend8(gfx_pix_i.r, video_pix_i.r, gfx_w, vid_w);
    blended.g = blend8(gfx_pix_i.g, video_pix_i.g, gfx_w, vid_w);
    blended.b = blend8(gfx_pix_i.b, video_pix_i.b, gfx_w, vid_w);
    h_start = {st_reg.regs.capture_h_overflow[`VOK_HOVF_START_MSB:0],
               st_reg.regs.capture_left_bound_low};
    h_end = {st_reg.regs.capture_h_overflow[`VOK_HOVF_END_MSB:`VOK_HOVF_END_LSB],
             st_reg.regs.capture_right_bound_low};
    v_start = {st_reg.regs.capture_v_overflow[`VOK_VOVF_START_MSB:0],
               st_reg.regs.capture_top_bound_low};
    v_end = {st_reg.regs.capture_v_overflow[`VOK_VOVF_END_MSB:`VOK_VOVF_END_LSB],
             st_reg.regs.capture_bottom_bound_low};
  end

  // Register read decode
  function automatic logic [7:0] reg_read(
    input vok_regs_t r,
    input logic [7:0] idx
  );
    case (idx)
      `VOK_IDX_VKEY_BY_LOW: reg_read = r.vkey_by_low;
      `VOK_IDX_VKEY_GU_LOW: reg_read = r.vkey_gu_low;
      `VOK_IDX_VKEY_RV_LOW: reg_read = r.vkey_rv_low;
      `VOK_IDX_VIDEO_MISC3: reg_read = r.video_misc3;
      `VOK_IDX_GKEY_B_HIGH: reg_read = r.graphics_key_blue_high;
      `VOK_IDX_GKEY_G_HIGH: reg_read = r.graphics_key_green_high;
      `VOK_IDX_GKEY_R_HIGH: reg_read = r.graphics_key_red_high;
      `VOK_IDX_VKEY_BY_HIGH: reg_read = r.video_key_blue_luma_high;
      `VOK_IDX_VKEY_GU_HIGH: reg_read = r.video_key_green_u_high;
      `VOK_IDX_VKEY_RV_HIGH: reg_read = r.video_key_red_v_high;
      `VOK_IDX_GFX_WEIGHT: reg_read = r.graphics_blend_weight;
      `VOK_IDX_VID_WEIGHT: reg_read = r.video_blend_weight;
      `VOK_IDX_MODE: reg_read = r.overlay_select_mode;
      `VOK_IDX_LEFT_LOW: reg_read = r.capture_left_bound_low;
      `VOK_IDX_RIGHT_LOW: reg_read = r.capture_right_bound_low;
      `VOK_IDX_TOP_LOW: reg_read = r.capture_top_bound_low;
      `VOK_IDX_BOTTOM_LOW: reg_read = r.capture_bottom_bound_low;
      `VOK_IDX_H_OVERFLOW: reg_read = r.capture_h_overflow;
      `VOK_IDX_V_OVERFLOW: reg_read = r.capture_v_overflow;
      default: reg_read = 8'h00;
    endcase
  endfunction : reg_read

  // Video clock edge and synchronised pins
  logic vclk_rise;
  logic vsync_rise;
  logic line_end;
  logic blank_n_now;
  logic in_window;

  always_comb begin
    st_next = st_reg;

    // Host port: index write, data write, read of index or data
    if (io_req_i.wr && !io_req_i.sel_data) begin
      st_next.io_index = io_req_i.wdata;
    end
    if (io_req_i.wr && io_req_i.sel_data) begin
      case (st_reg.io_index)
        `VOK_IDX_VKEY_BY_LOW: begin
          st_next.regs.vkey_by_low = io_req_i.wdata;
        end
        `VOK_IDX_VKEY_GU_LOW: begin
          st_next.regs.vkey_gu_low = io_req_i.wdata;
        end
        `VOK_IDX_VKEY_RV_LOW: begin
          st_next.regs.vkey_rv_low = io_req_i.wdata;
        end
        `VOK_IDX_VIDEO_MISC3: begin
          st_next.regs.video_misc3 = io_req_i.wdata;
        end
        `VOK_IDX_GKEY_B_HIGH: begin
          st_next.regs.graphics_key_blue_high = io_req_i.wdata;
        end
        `VOK_IDX_GKEY_G_HIGH: begin
          st_next.regs.graphics_key_green_high = io_req_i.wdata;
        end
        `VOK_IDX_GKEY_R_HIGH: begin
          st_next.regs.graphics_key_red_high = io_req_i.wdata;
        end
        `VOK_IDX_VKEY_BY_HIGH: begin
          st_next.regs.video_key_blue_luma_high = io_req_i.wdata;
        end
        `VOK_IDX_VKEY_GU_HIGH: begin
          st_next.regs.video_key_green_u_high = io_req_i.wdata;
        end
        `VOK_IDX_VKEY_RV_HIGH: begin
          st_next.regs.video_key_red_v_high = io_req_i.wdata;
        end
        `VOK_IDX_GFX_WEIGHT: begin
          st_next.regs.graphics_blend_weight = io_req_i.wdata;
        end
        `VOK_IDX_VID_WEIGHT: begin
          st_next.regs.video_blend_weight = io_req_i.wdata;
        end
        `VOK_IDX_MODE: begin
          // Reserved bits dropped, so they read back as zero
          st_next.regs.overlay_select_mode = io_req_i.wdata & `VOK_MODE_MASK;
        end
        `VOK_IDX_LEFT_LOW: begin
          st_next.regs.capture_left_bound_low = io_req_i.wdata;
        end
        `VOK_IDX_RIGHT_LOW: begin
          st_next.regs.capture_right_bound_low = io_req_i.wdata;
        end
        `VOK_IDX_TOP_LOW: begin
          st_next.regs.capture_top_bound_low = io_req_i.wdata;
        end
        `VOK_IDX_BOTTOM_LOW: begin
          st_next.regs.capture_bottom_bound_low = io_req_i.wdata;
        end
        `VOK_IDX_H_OVERFLOW: begin
          st_next.regs.capture_h_overflow = io_req_i.wdata & `VOK_HOVF_MASK;
        end
        `VOK_IDX_V_OVERFLOW: begin
          st_next.regs.capture_v_overflow = io_req_i.wdata;
        end
        default: st_next.regs = st_reg.regs;
      endcase
    end
    // Reads see the value from before any write of the same cycle
    if (io_req_i.rd) begin
      st_next.io_rdata = io_req_i.sel_data ? reg_read(st_reg.regs, st_reg.io_index)
                                           : st_reg.io_index;
    end

    // Mixer output, one pixel per clock
    st_next.mix_pix = mode_pick(mode, color_key, chroma_key) ? blended
                                                           : gfx_pix_i;

    // Two-stage synchronisers for the decoder pins
    st_next.pin_s1 = {video_in_vertical_sync_i, vid_blank_n_i, vid_clk_i};
    st_next.pin_s2 = st_reg.pin_s1;
    // Data sampled with the pins, so it is settled at the clock edge
    st_next.data_s1 = vid_data_i;
    st_next.data_s2 = st_reg.data_s1;
    st_next.vclk_d = st_reg.pin_s2[PIN_VCLK];

    vclk_rise = st_reg.pin_s2[PIN_VCLK] & ~st_reg.vclk_d;
    blank_n_now = st_reg.pin_s2[PIN_BLANK];
    vsync_rise = st_reg.pin_s2[PIN_VSYNC] & ~st_reg.vsync_d;
    line_end = st_reg.blank_n_d & ~blank_n_now;
    // Bounds test uses the counts from before this edge's update
    in_window = (st_reg.hcnt >= h_start) && (st_reg.vcnt >= v_start)
              && !((st_reg.hcnt >= h_end) || (st_reg.vcnt >= v_end));

    st_next.cap_valid = 1'b0;
    if (vclk_rise) begin
      st_next.vsync_d = st_reg.pin_s2[PIN_VSYNC];
      st_next.blank_n_d = blank_n_now;
      // Horizontal counter holds at zero during blanking
      // Saturates rather than wraps, so a long line cannot re-enter
      if (!blank_n_now) begin
        st_next.hcnt = '0;
      end else if (st_reg.hcnt != '1) begin
        st_next.hcnt = st_reg.hcnt + 1'b1;
      end

      // Lines counted as blanking starts, at the falling edge of vid_blank_n_i
      if (vsync_rise) begin
        st_next.vcnt = '0;
      end else if (line_end && st_reg.vcnt != '1) begin
        st_next.vcnt = st_reg.vcnt + 1'b1;
      end

      case (st_reg.cap_state)
        VOK_CAP_WAIT_FRAME: begin
          // Nothing captured before the first frame start
          if (vsync_rise) begin
            st_next.cap_state = VOK_CAP_IN_FRAME;
          end
          st_next.cap_window = 1'b0;
        end
        VOK_CAP_IN_FRAME: begin
          st_next.cap_window = in_window && blank_n_now;
          if (in_window && blank_n_now && !vsync_rise) begin
            st_next.cap_valid = 1'b1;
            st_next.cap_data = st_reg.data_s2;
          end
        end
        default: st_next.cap_state = VOK_CAP_WAIT_FRAME;
      endcase
    end
  end

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st_reg <= '0;
      // Every register comes up at its reset value
      st_reg.regs <= {$bits(vok_regs_t)/8{`VOK_REG_RESET}};
      st_reg.cap_state <= VOK_CAP_WAIT_FRAME;
    end else begin
      st_reg <= st_next;
    end
  end

  assign io_rdata_o = st_reg.io_rdata;
  assign mix_pix_o = st_reg.mix_pix;
  assign capture_valid_o = st_reg.cap_valid;
  assign capture_data_o = st_reg.cap_data;
  assign capture_window_o = st_reg.cap_window;

endmodule : vok_overlay_capture

// *** verif/vok_vrf_pkg.sv ***
// Reference blend arithmetic shared by the checker and the bench.
// Assumes vok_pkg for the pixel type.
package vok_vrf_pkg;
  import vok_pkg::*;

  function automatic logic [7:0] mix_byte(input logic [7:0] g, input logic [7:0] v,
                                          input logic [2:0] gw, input logic [2:0] vw);
    logic [11:0] s;
    s = ({4'h0, g} * {9'h000, gw} + {4'h0, v} * {9'h000, vw}) >> 3;
    return (s > 12'h0FF) ? 8'hFF : s[7:0];
  endfunction : mix_byte

  function automatic vok_rgb_t blend(input vok_rgb_t g, input vok_rgb_t v,
                                     input logic [2:0] gw, input logic [2:0] vw);
    return '{mix_byte(g.r, v.r, gw, vw), mix_byte(g.g, v.g, gw, vw), mix_byte(g.b, v.b, gw, vw)};
  endfunction : blend
endpackage : vok_vrf_pkg

// *** verif/vok_decoder_model.sv ***
// Video decoder stand-in: pixel clock, blanking, vertical sync and data.
// Assumes one start pulse per frame; its clock stands still between frames.
`timescale 1ns/1ps

module vok_decoder_model #(
  parameter int PIX = 264,
  parameter int LINES = 4
) (
  // Frame request and status
  input wire logic start_i,
  output logic busy_o,
  // Decoder pins
  output logic vid_clk_o,
  output logic vid_blank_n_o,
  output logic vsync_o,
  output logic [15:0] data_o
);
  // One pixel period; pins change while the clock is low
  task automatic tick(input logic bl_n, input logic vs, input logic [15:0] d);
    vid_clk_o = 1'b0;
    vid_blank_n_o = bl_n;
    vsync_o = vs;
    data_o = d;
    #16;
    vid_clk_o = 1'b1;
    #16;
  endtask : tick

  initial begin
    {busy_o, vid_clk_o, vid_blank_n_o, vsync_o} = 4'h0;
    data_o = 16'h0000;
    forever begin
      @(posedge start_i);
      busy_o = 1'b1;
      repeat (2) tick(1'b0, 1'b0, ~data_o);
      repeat (4) tick(1'b0, 1'b1, ~data_o);
      for (int l = 0; l < LINES; l++) begin
        for (int p = 0; p < PIX; p++) tick(1'b1, 1'b0, {4'(l), 12'(p)});
        repeat (4) tick(1'b0, 1'b0, ~data_o);
      end
      vid_clk_o = 1'b0;
      busy_o = 1'b0;
    end
  end
endmodule : vok_decoder_model

// *** verif/vok_overlay_capture_chk.sv ***
// Port checks of the overlay key mixer and capture window.
// Assumes binding to the design top; shadows the registers it needs.
`timescale 1ns/1ps
`include "vok_defs.svh"

module vok_overlay_capture_chk
  import vok_pkg::*, vok_vrf_pkg::*;
#(
  parameter int DATA_W = 16
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic reset_n_i,
  // Host port and mixer
  input wire vok_io_req_t io_req_i,
  input wire logic [7:0] io_rdata_o,
  input wire vok_rgb_t gfx_pix_i,
  input wire vok_rgb_t video_pix_i,
  input wire vok_rgb_t mix_pix_o,
  // Capture side
  input wire logic vid_blank_n_i,
  input wire logic capture_valid_o,
  input wire logic [DATA_W-1:0] capture_data_o,
  input wire logic capture_window_o
);
  logic [7:0] idx_reg, mode_reg, gw_reg, vw_reg, hend_reg, hovf_reg, vend_reg, vovf_reg;
  vok_rgb_t gfx_reg, blend_reg;
  logic [10:0] hend_w;
  logic [9:0] vend_w;
  assign hend_w = {hovf_reg[`VOK_HOVF_END_MSB:`VOK_HOVF_END_LSB], hend_reg};
  assign vend_w = {vovf_reg[`VOK_VOVF_END_MSB:`VOK_VOVF_END_LSB], vend_reg};

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      {idx_reg, mode_reg, gw_reg, vw_reg, hend_reg, hovf_reg, vend_reg, vovf_reg} <= '0;
    end else if (io_req_i.wr && !io_req_i.sel_data) begin
      idx_reg <= io_req_i.wdata;
    end else if (io_req_i.wr) begin
      case (idx_reg)
        `VOK_IDX_MODE: mode_reg <= io_req_i.wdata;
        `VOK_IDX_GFX_WEIGHT: gw_reg <= io_req_i.wdata;
        `VOK_IDX_VID_WEIGHT: vw_reg <= io_req_i.wdata;
        `VOK_IDX_RIGHT_LOW: hend_reg <= io_req_i.wdata;
        `VOK_IDX_H_OVERFLOW: hovf_reg <= io_req_i.wdata;
        `VOK_IDX_BOTTOM_LOW: vend_reg <= io_req_i.wdata;
        `VOK_IDX_V_OVERFLOW: vovf_reg <= io_req_i.wdata;
        default: ;
      endcase
    end
  end

  // Expected mixer candidates for the next cycle
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      {gfx_reg, blend_reg} <= '0;
    end else begin
      gfx_reg <= gfx_pix_i;
      blend_reg <= blend(gfx_pix_i, video_pix_i, gw_reg[7:5], vw_reg[7:5]);
    end
  end

  default clocking @(posedge mclk_i); endclocking
  default disable iff (!reset_n_i);

  a_valid_pulse: assert property (capture_valid_o |=> !capture_valid_o)
    else $error("capture valid held");
  a_valid_window: assert property (capture_valid_o |-> capture_window_o)
    else $error("capture outside window");
  a_data_hold: assert property (!capture_valid_o |-> $stable(capture_data_o))
    else $error("capture data moved");
  a_blank_idle: assert property (!vid_blank_n_i [*6] |-> !capture_valid_o)
    else $error("capture during blanking");
  a_gfx_only: assert property (mode_reg[3:0] == `VOK_MODE_GFX |=> mix_pix_o == gfx_reg)
    else $error("mode 0 not graphics");
  a_blend_only: assert property (mode_reg[3:0] == `VOK_MODE_BLEND |=> mix_pix_o == blend_reg)
    else $error("mode F not blended");
  a_mix_source: assert property (1'b1 |=> mix_pix_o == gfx_reg || mix_pix_o == blend_reg)
    else $error("mixer output from no source");
  a_mode_read: assert property (io_req_i.rd && io_req_i.sel_data && idx_reg == `VOK_IDX_MODE
    |=> io_rdata_o == {4'h0, $past(mode_reg[3:0])})
    else $error("mode read wrong");
  a_rdata_hold: assert property (!io_req_i.rd |=> $stable(io_rdata_o))
    else $error("read data moved");
  a_no_end: assert property ((hend_w == 11'h000 || vend_w == 10'h000) [*3] |-> !capture_valid_o)
    else $error("capture with zero end");
endmodule : vok_overlay_capture_chk

// *** verif/vok_overlay_capture_tb_top.sv ***
// Bench of the overlay key mixer and capture window.
// Assumes the decoder stand-in and the checker bound at the foot.
`timescale 1ns/1ps
`include "vok_defs.svh"

module vok_overlay_capture_tb_top
  import vok_pkg::*, vok_vrf_pkg::*;
;
  logic mclk_i, reset_n_i, vid_clk_i, vid_blank_n_i, video_in_vertical_sync_i;
  logic capture_valid_o, capture_window_o, frame_start, frame_busy;
  vok_io_req_t io_req_i;
  logic [7:0] io_rdata_o;
  logic [1:0] color_depth_i;
  logic [23:0] graphics_key_low_i;
  vok_rgb_t gfx_pix_i, video_pix_i, mix_pix_o;
  logic [15:0] vid_data_i, capture_data_o;
  logic [15:0] capq[$];
  int err_total = 0;
  int total_checks = 0;
  int cyc = 0;
  // Blend select per mode, indexed by {colour key, chroma key}
  localparam logic [3:0] SEL_TBL [16] = '{4'h0, 4'h8, 4'h4, 4'hC, 4'h2, 4'hA, 4'h6, 4'hE,
                                         4'h1, 4'h9, 4'h5, 4'hD, 4'h5, 4'hB, 4'h7, 4'hF};

  vok_overlay_capture u_vok_overlay_capture (.mclk_i(mclk_i), .reset_n_i(reset_n_i),
    .io_req_i(io_req_i), .io_rdata_o(io_rdata_o), .color_depth_i(color_depth_i),
    .graphics_key_low_i(graphics_key_low_i), .gfx_pix_i(gfx_pix_i),
    .video_pix_i(video_pix_i), .mix_pix_o(mix_pix_o), .vid_clk_i(vid_clk_i),
    .vid_blank_n_i(vid_blank_n_i), .video_in_vertical_sync_i(video_in_vertical_sync_i),
    .vid_data_i(vid_data_i), .capture_valid_o(capture_valid_o),
    .capture_data_o(capture_data_o), .capture_window_o(capture_window_o));

  vok_decoder_model u_vok_decoder_model (.start_i(frame_start), .busy_o(frame_busy),
    .vid_clk_o(vid_clk_i), .vid_blank_n_o(vid_blank_n_i),
    .vsync_o(video_in_vertical_sync_i), .data_o(vid_data_i));

  initial begin
    mclk_i = 1'b0;
    forever #2 mclk_i = ~mclk_i;
  end

  always @(negedge mclk_i) if (capture_valid_o === 1'b1) begin
    capq.push_back(capture_data_o);
    check({23'h000000, capture_window_o}, 24'h000001);
  end

  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 40000) begin
      err_total++;
      final_report();
    end
  end

  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask : check

  task automatic io_op(input logic sel, input logic wr, input logic [7:0] d);
    @(negedge mclk_i);
    io_req_i = '{sel, wr, ~wr, d};
  endtask : io_op

  task automatic io_wr(input logic [7:0] idx, input logic [7:0] d);
    io_op(1'b0, 1'b1, idx);
    io_op(1'b1, 1'b1, d);
    @(negedge mclk_i) io_req_i = '0;
  endtask : io_wr

  task automatic io_rd(input logic [7:0] idx, input logic [7:0] exp);
    io_op(1'b0, 1'b1, idx);
    io_op(1'b1, 1'b0, 8'h00);
    @(negedge mclk_i) io_req_i = '0;
    check({16'h0000, io_rdata_o}, {16'h0000, exp});
  endtask : io_rd

  // Weights 9Fh and 7Fh give 4 and 3 in the top bits
  task automatic chk_mix(input logic [3:0] m, input logic [1:0] d, input vok_rgb_t g,
                         input vok_rgb_t v, input logic sel);
    io_wr(`VOK_IDX_MODE, {4'hF, m});
    @(negedge mclk_i);
    color_depth_i = d;
    gfx_pix_i = g;
    video_pix_i = v;
    @(negedge mclk_i) check(mix_pix_o, sel ? blend(g, v, 3'h4, 3'h3) : g);
  endtask : chk_mix

  task automatic end_test(input string name);
    $display("Test %s done, mismatches %0d", name, err_total);
  endtask : end_test

  task automatic final_report();
    $display("Checks %0d, mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : final_report

  initial begin
    vok_rgb_t g, v;
    reset_n_i = 1'b0;
    io_req_i = '0;
    color_depth_i = `VOK_DEPTH_24;
    graphics_key_low_i = 24'h101010;
    gfx_pix_i = '0;
    video_pix_i = '0;
    frame_start = 1'b0;
    repeat (3) @(negedge mclk_i);
    reset_n_i = 1'b1;
    for (int i = 0; i < 11; i++) io_rd(8'hA3 + 8'(i), `VOK_REG_RESET);
    io_wr(8'h90, 8'hFF);
    io_rd(8'h90, 8'h00);
    for (int i = 0; i < 11; i++) io_wr(8'hA3 + 8'(i), 8'hC3 + 8'(i));
    for (int i = 0; i < 11; i++) io_rd(8'hA3 + 8'(i), (i == 6) ? 8'h09 : 8'hC3 + 8'(i));
    end_test("registers");
    for (int i = 0; i < 3; i++) begin
      io_wr(8'hA1 + 8'(i), 8'h20);
      io_wr(8'h9A + 8'(i), 8'h40);
      io_wr(8'hA4 + 8'(i), 8'h50);
    end
    io_wr(`VOK_IDX_GFX_WEIGHT, 8'h9F);
    io_wr(`VOK_IDX_VID_WEIGHT, 8'h7F);
    for (int m = 0; m < 16; m++) begin
      for (int c = 0; c < 4; c++) begin
        g = c[1] ? 24'h151515 : 24'h301515;
        v = 24'h454545 ^ (c[0] ? 24'h000000 : 24'h000025 << (8 * (m % 3)));
        chk_mix(4'(m), `VOK_DEPTH_24, g, v, SEL_TBL[m][c]);
      end
    end
    chk_mix(`VOK_MODE_C, `VOK_DEPTH_8, 24'h303015, 24'h000000, 1'b1);
    chk_mix(`VOK_MODE_C, `VOK_DEPTH_16, 24'h301515, 24'h000000, 1'b1);
    chk_mix(`VOK_MODE_C, `VOK_DEPTH_24, 24'h101010, 24'h000000, 1'b1);
    chk_mix(`VOK_MODE_C, `VOK_DEPTH_24, 24'h202021, 24'h000000, 1'b0);
    io_wr(`VOK_IDX_VIDEO_MISC3, 8'h04);
    chk_mix(`VOK_MODE_CH, `VOK_DEPTH_24, 24'h151515, 24'h404040, 1'b1);
    chk_mix(`VOK_MODE_CH, `VOK_DEPTH_24, 24'h151515, 24'h505050, 1'b1);
    chk_mix(`VOK_MODE_CH, `VOK_DEPTH_24, 24'h151515, 24'h505051, 1'b0);
    end_test("mixer");
    io_wr(`VOK_IDX_LEFT_LOW, 8'h02);
    io_wr(`VOK_IDX_RIGHT_LOW, 8'h05);
    io_wr(`VOK_IDX_H_OVERFLOW, 8'h11);
    io_wr(`VOK_IDX_TOP_LOW, 8'h01);
    io_wr(`VOK_IDX_BOTTOM_LOW, 8'h03);
    io_wr(`VOK_IDX_V_OVERFLOW, 8'h04);
    @(negedge mclk_i) frame_start = 1'b1;
    @(negedge mclk_i) frame_start = 1'b0;
    for (int i = 0; i < 20000 && frame_busy !== 1'b0; i++) @(negedge mclk_i);
    repeat (8) @(negedge mclk_i);
    check(24'(capq.size()), 24'h000009);
    for (int k = 0; k < 9 && capq.size() > 0; k++) begin
      check({8'h00, capq.pop_front()}, {8'h00, 4'(1 + k / 3), 12'(258 + k % 3)});
    end
    end_test("capture");
    final_report();
  end
endmodule : vok_overlay_capture_tb_top

bind vok_overlay_capture vok_overlay_capture_chk #(.DATA_W(DATA_W)) u_vok_overlay_capture_chk (
  .mclk_i(mclk_i), .reset_n_i(reset_n_i), .io_req_i(io_req_i), .io_rdata_o(io_rdata_o),
  .gfx_pix_i(gfx_pix_i), .video_pix_i(video_pix_i), .mix_pix_o(mix_pix_o),
  .vid_blank_n_i(vid_blank_n_i), .capture_valid_o(capture_valid_o),
  .capture_data_o(capture_data_o), .capture_window_o(capture_window_o));
